// ---- hw/lcd_seg_map.svh ----
// Register offsets, field positions, reset values and counts of the
// segment display driver control block.
// Assumes a byte-wide register port with a 5-bit address.
`ifndef LCD_SEG_MAP_SVH
`define LCD_SEG_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define LCD_OFF_MAIN 5'h00
`define LCD_OFF_PHASE 5'h01
`define LCD_OFF_REF 5'h02
`define LCD_OFF_CST 5'h03
`define LCD_OFF_SEGEN0 5'h04
`define LCD_OFF_SEGEN2 5'h06
`define LCD_OFF_DATA0 5'h08
`define LCD_OFF_DATA11 5'h13

// ****************************************
// Field positions
// ****************************************
`define LCD_BIT_EN 7
`define LCD_BIT_SDIS 6
`define LCD_BIT_WRITE_ERROR_FLAG 5
`define LCD_BIT_WFT 7
`define LCD_BIT_BIAS 6
`define LCD_BIT_ACT 5
`define LCD_BIT_WA 4
`define LCD_BIT_IRE 7
`define LCD_BIT_IRS 6
`define LCD_BIT_IRI 5

// ****************************************
// Reset values and write masks
// ****************************************
`define LCD_RST_MAIN 8'h03
`define LCD_RST_PHASE 8'h03
`define LCD_MASK_MAIN 8'hCF
`define LCD_MASK_PHASE 8'hCF
`define LCD_MASK_REF 8'hEE

// ****************************************
// Counts
// ****************************************
`define LCD_SYSDIV_LAST 8'hFF
`define LCD_PIX_REGS 12

`endif

// ---- hw/lcd_seg_pkg.sv ----
// Types shared by the segment display driver control block.
// Assumes the map header supplies every number.
package lcd_seg_pkg;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } seq_state_e;

  // ****************************************
  // Analog front-end controls
  // ****************************************
  typedef struct packed {
    logic bias_static;
    logic bias_half;
    logic ladder_on;
    logic contrast_on;
    logic [2:0] contrast_level;
    logic ref_enable;
    logic ref_from_fvr;
    logic ref_buffer_on;
    logic [2:0] bias_pin_en;
  } analog_ctrl_s;

endpackage : lcd_seg_pkg

// ---- hw/lcd_segment_driver_control.sv ----
// Control, clock selection, prescaler, common sequencing and pixel
// storage of a segment display driver with 4 commons and 24 segments.
// Assumes all inputs synchronous to i_clk_sys, oscillator inputs slow
// compared to it, and a master that never strobes read and write at once.
//
// Summary of operation
// - Enable bit switches whole driver, resets low
// - Sleep-disable bit stops driver during processor sleep
// - Pixel write without write allow sets error
// - Error flag sticky; software clears by zero
// - Source field picks sysclk/256, crystal, internal
// - Divide by 256 is fixed
// - Commons field selects multiplex, resets to four
// - Waveform bit picks per-common or per-frame phase
// - Active status shows driver really running
// - Write allow status shows permitted write window
// - Prescaler ratio is field value plus one
// - Prescaler counter hidden from software
// - Reference enable bit powers internal reference
// - Reference source picks supply or fixed reference
// - Ladder-idle bit drops buffer in mode B
// - Bias pin bits connect pins to bias
// - Contrast field sets ladder resistance sevenths
// - Segment enable bits give pins, reset zero
// - Pixel bits dark when one, never reset
// - Oscillator sources keep running in sleep
// - Three pixel registers per common
// - Inactive driver turns reference and ladders off
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "lcd_seg_map.svh"

module lcd_segment_driver_control (
  // Clock, reset, freeze
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_clk_en,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  // System state and clock sources
  input wire logic i_sleep,
  input wire logic i_xtal_32k,
  input wire logic i_lfosc_31k,
  input wire logic i_ladder_mode_b,
  // Glass drive
  output logic [23:0] o_seg_data,
  output logic [23:0] o_seg_pin_en,
  output logic [3:0] o_com_sel,
  output logic o_phase,
  output logic o_active,
  // Analog controls
  output lcd_seg_pkg::analog_ctrl_s o_analog
);

  // ****************************************
  // Registers and state
  // ****************************************
  logic [7:0] main_q;
  logic write_error_flag_q;
  logic [7:0] phase_q;
  logic [7:0] ref_q;
  logic [2:0] cst_q;
  logic [7:0] segen_q [3];
  logic [7:0] pixel_q [`LCD_PIX_REGS];
  logic [7:0] rd_q;
  logic active_q;
  logic wa_q;
  lcd_seg_pkg::seq_state_e state_q;
  logic [7:0] sysdiv_q;
  logic xtal_prev_q;
  logic lfo_prev_q;
  logic [3:0] presc_q;
  logic [1:0] com_q;
  logic phase_bit_q;
  logic load_q;
  logic [23:0] seg_q;
  logic [3:0] com_sel_q;
  logic phase_out_q;
  lcd_seg_pkg::analog_ctrl_s analog_q;

  // ****************************************
  // Address decode
  // ****************************************
  // Offsets outside every window read zero and ignore writes
  wire sel_main = (i_addr == `LCD_OFF_MAIN);
  wire sel_phase = (i_addr == `LCD_OFF_PHASE);
  wire sel_ref = (i_addr == `LCD_OFF_REF);
  wire sel_cst = (i_addr == `LCD_OFF_CST);
  wire sel_seg = (i_addr >= `LCD_OFF_SEGEN0) && (i_addr <= `LCD_OFF_SEGEN2);
  wire sel_pix = (i_addr >= `LCD_OFF_DATA0) && (i_addr <= `LCD_OFF_DATA11);
  wire [1:0] seg_idx = 2'(i_addr - `LCD_OFF_SEGEN0);
  wire [3:0] pix_idx = 4'(i_addr - `LCD_OFF_DATA0);
  wire wr_main = i_wr_en && sel_main;
  wire wr_pix = i_wr_en && sel_pix;
  wire wr_pix_ok = wr_pix && wa_q; // Refused writes leave the pixel alone

  // ****************************************
  // Field views
  // ****************************************
  // Unimplemented bits are masked on write, so these views never see them
  wire drv_en = main_q[`LCD_BIT_EN];
  wire sleep_dis = main_q[`LCD_BIT_SDIS];
  wire [1:0] clk_src = main_q[3:2];
  wire [1:0] commons = main_q[1:0];
  wire wave_b = phase_q[`LCD_BIT_WFT];
  wire bias_bit = phase_q[`LCD_BIT_BIAS];
  wire [3:0] presc_sel = phase_q[3:0];

  // ****************************************
  // Run decision
  // ****************************************
  // The sysclk-derived source dies in sleep, so it cannot keep the glass alive
  wire src_sleeps = (clk_src == 2'b00);
  wire sleep_stop = i_sleep && (sleep_dis || src_sleeps);
  wire run_req = drv_en && !sleep_stop;

  // ****************************************
  // Clock source ticks
  // ****************************************
  // Oscillators are sampled as levels; a rising edge is one driver tick
  wire sys_tick = (sysdiv_q == `LCD_SYSDIV_LAST);
  wire xtal_tick = i_xtal_32k && !xtal_prev_q;
  wire lfo_tick = i_lfosc_31k && !lfo_prev_q;
  wire src_tick = (clk_src == 2'b00) ? sys_tick :
                  (clk_src == 2'b01) ? xtal_tick : lfo_tick;
  wire running = (state_q == lcd_seg_pkg::ST_RUN);
  wire presc_hit = running && src_tick && (presc_q == presc_sel);

  // ****************************************
  // Common and phase stepping
  // ****************************************
  // Commons beyond a newly shrunk multiplex wrap at once, not next frame
  wire com_last = (com_q >= commons);
  wire [1:0] com_next = com_last ? 2'b00 : 2'(com_q + 2'b01);
  // Type A steps the common every second prescaler hit, type B every hit
  wire step_com = wave_b ? 1'b1 : phase_bit_q;
  wire flip_phase = wave_b ? com_last : 1'b1;

  // ****************************************
  // Pixel selection for the current common
  // ****************************************
  wire [3:0] pix_base = {1'b0, com_q, 1'b0} + {2'b00, com_q};
  wire [23:0] seg_word = {pixel_q[pix_base + 4'd2], pixel_q[pix_base + 4'd1],
                          pixel_q[pix_base]};

  // ****************************************
  // Analog control decode
  // ****************************************
  wire ire = ref_q[`LCD_BIT_IRE];
  wire mid_mux = (commons == 2'b01) || (commons == 2'b10);
  lcd_seg_pkg::analog_ctrl_s analog_d;
  assign analog_d.bias_static = (commons == 2'b00);
  assign analog_d.bias_half = mid_mux && bias_bit;
  // Built from the run request so the ladders drop in the same cycle as the status bit
  assign analog_d.ladder_on = run_req;
  assign analog_d.contrast_on = run_req && ire;
  assign analog_d.contrast_level = cst_q;
  assign analog_d.ref_enable = run_req && ire;
  assign analog_d.ref_from_fvr = ire && ref_q[`LCD_BIT_IRS];
  // Buffer idles in ladder mode B only when asked to
  assign analog_d.ref_buffer_on = run_req && ire &&
                                  !(ref_q[`LCD_BIT_IRI] && i_ladder_mode_b);
  assign analog_d.bias_pin_en = ref_q[3:1];

  // ****************************************
  // Read mux
  // ****************************************
  // Unimplemented bits read as zero
  wire [7:0] rd_main = {main_q[7:6], write_error_flag_q, 1'b0, main_q[3:0]};
  wire [7:0] rd_phase = {phase_q[7:6], active_q, wa_q, phase_q[3:0]};
  // Prescaler count has no read path on purpose
  wire [7:0] rd_word = sel_main ? rd_main :
                       sel_phase ? rd_phase :
                       sel_ref ? ref_q :
                       sel_cst ? {5'h00, cst_q} :
                       sel_seg ? segen_q[seg_idx] :
                       sel_pix ? pixel_q[pix_idx] : 8'h00;

  // ****************************************
  // Write error flag
  // ****************************************
  // A new error beats a clear in the same cycle
  // The flag only clears through the main register, never by itself
  wire write_error_flag_set = wr_pix && !wa_q;
  wire write_error_flag_clr = wr_main && !i_wr_data[`LCD_BIT_WRITE_ERROR_FLAG];
  wire write_error_flag_d = write_error_flag_set ? 1'b1 : (write_error_flag_clr ? 1'b0 : write_error_flag_q);

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      main_q <= `LCD_RST_MAIN;
      phase_q <= `LCD_RST_PHASE;
      ref_q <= 8'h00;
      cst_q <= 3'h0;
      write_error_flag_q <= 1'b0;
    end else if (i_clk_en) begin
      write_error_flag_q <= write_error_flag_d;
      if (wr_main) begin
        main_q <= i_wr_data & `LCD_MASK_MAIN;
      end
      if (i_wr_en && sel_phase) begin
        phase_q <= i_wr_data & `LCD_MASK_PHASE;
      end
      if (i_wr_en && sel_ref) begin
        ref_q <= i_wr_data & `LCD_MASK_REF;
      end
      if (i_wr_en && sel_cst) begin
        cst_q <= i_wr_data[2:0];
      end
    end
  end

  // ****************************************
  // Segment enable and pixel storage
  // ****************************************
  // Byte n of the enables drives segment pins 8n+7 down to 8n
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_segen
      // Segment pins start as general I/O
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          segen_q[gi] <= 8'h00;
        end else if (i_clk_en && i_wr_en && sel_seg && (seg_idx == 2'(gi))) begin
          segen_q[gi] <= i_wr_data;
        end
      end
    end
    for (gi = 0; gi < `LCD_PIX_REGS; gi++) begin : g_pix
      // No reset: the picture survives a warm reset
      always_ff @(posedge i_clk_sys) begin
        if (i_clk_en && wr_pix_ok && (pix_idx == 4'(gi))) begin
          pixel_q[gi] <= i_wr_data;
        end
      end
    end
  endgenerate

  // ****************************************
  // Read data, one cycle after the strobe
  // ****************************************
  // Idle cycles return zero so a stale byte never looks like an answer
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      rd_q <= 8'h00;
    end else if (i_clk_en) begin
      rd_q <= i_rd_en ? rd_word : 8'h00;
    end
  end

  // ****************************************
  // Status and clock source tracking
  // ****************************************
  // Write allow drops for the cycle the segment latch reloads after a prescaler hit, not for the start load
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      active_q <= 1'b0;
      wa_q <= 1'b1;
      sysdiv_q <= 8'h00;
      xtal_prev_q <= 1'b0;
      lfo_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      active_q <= run_req;
      wa_q <= !presc_hit;
      sysdiv_q <= 8'(sysdiv_q + 8'h01);
      xtal_prev_q <= i_xtal_32k;
      lfo_prev_q <= i_lfosc_31k;
    end
  end

  // ****************************************
  // Sequencer state
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_q <= lcd_seg_pkg::ST_IDLE;
    end else if (i_clk_en) begin
      case (state_q)
        lcd_seg_pkg::ST_IDLE: begin
          if (run_req) begin
            state_q <= lcd_seg_pkg::ST_RUN;
          end
        end
        lcd_seg_pkg::ST_RUN: begin
          if (!run_req) begin
            state_q <= lcd_seg_pkg::ST_IDLE;
          end
        end
        // An unused code falls back to idle rather than running blind
        default: begin
          state_q <= lcd_seg_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Prescaler, common and phase counters
  // ****************************************
  // Counters restart from common 0 every time the driver starts
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      presc_q <= 4'h0;
      com_q <= 2'b00;
      phase_bit_q <= 1'b0;
    end else if (i_clk_en) begin
      if (!running) begin
        presc_q <= 4'h0;
        com_q <= 2'b00;
        phase_bit_q <= 1'b0;
      end else if (presc_hit) begin
        presc_q <= 4'h0;
        if (step_com) begin
          com_q <= com_next;
        end
        if (flip_phase) begin
          phase_bit_q <= !phase_bit_q;
        end
      // Between hits the hidden count only steps on source ticks
      end else if (src_tick) begin
        presc_q <= 4'(presc_q + 4'h1);
      end
    end
  end

  // ****************************************
  // Glass drive latches
  // ****************************************
  // Loading one cycle after the step lets the new common settle first
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      load_q <= 1'b0;
      seg_q <= 24'h00_0000;
      com_sel_q <= 4'h0;
      phase_out_q <= 1'b0;
      analog_q <= '0;
    end else if (i_clk_en) begin
      load_q <= presc_hit || (run_req && !running);
      analog_q <= analog_d;
      if (!running) begin
        seg_q <= 24'h00_0000;
        com_sel_q <= 4'h0;
        phase_out_q <= 1'b0;
      end else if (load_q) begin
        seg_q <= seg_word;
        com_sel_q <= 4'b0001 << com_q;
        phase_out_q <= phase_bit_q;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Each output is a flop, so the pads see no decode glitches
  assign o_rd_data = rd_q;
  assign o_seg_data = seg_q;
  assign o_seg_pin_en = {segen_q[2], segen_q[1], segen_q[0]};
  assign o_com_sel = com_sel_q;
  assign o_phase = phase_out_q;
  assign o_active = active_q;
  assign o_analog = analog_q;

endmodule : lcd_segment_driver_control

// ---- sim/lcd_glass_panel.sv ----
// Behavioural glass panel: keeps the last segment row seen on each common.
// Assumes one-hot commons and segment data that settle on the system clock.
`timescale 1ns/1ps

module lcd_glass_panel (
  // Clock
  input wire logic i_clk,
  // Glass drive
  input wire logic [3:0] i_com_sel,
  input wire logic [23:0] i_seg_data,
  // Picture, 24 segments per common
  output logic [95:0] o_image
);
  // Rows stay unknown until their common is first driven
  always_ff @(posedge i_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (i_com_sel[k]) begin
        o_image[k*24 +: 24] <= i_seg_data;
      end
    end
  end
endmodule : lcd_glass_panel

// ---- sim/lcd_segment_driver_control_monitor.sv ----
// Port checker for the segment display driver control block.
// Assumes a single clock domain and a bind onto the top module.
`timescale 1ns/1ps
`include "lcd_seg_map.svh"

module lcd_segment_driver_control_monitor (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_clk_en,
  // Register port
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  // Outputs watched
  input wire logic [23:0] o_seg_data,
  input wire logic [3:0] o_com_sel,
  input wire logic o_active,
  input wire lcd_seg_pkg::analog_ctrl_s o_analog
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  // Clearing the enable bit stops the driver two cycles later
  property p_disable_stops;
    (i_wr_en && i_clk_en && i_addr == `LCD_OFF_MAIN && !i_wr_data[7]) |=> ##1 !o_active;
  endproperty
  a_disable_stops: assert property (p_disable_stops) else $error("driver still active after disable");

  // An idle driver keeps every analog consumer off
  property p_idle_analog_off;
    !o_active |-> !(o_analog.ladder_on || o_analog.contrast_on || o_analog.ref_enable || o_analog.ref_buffer_on);
  endproperty
  a_idle_analog_off: assert property (p_idle_analog_off) else $error("analog on while inactive");

  property p_one_common;
    $onehot0(o_com_sel);
  endproperty
  a_one_common: assert property (p_one_common) else $error("more than one common driven");

  // Glass outputs rest at zero while stopped
  property p_idle_glass;
    (!o_active && !$past(o_active)) |-> (o_com_sel == 4'h0 && o_seg_data == 24'h00_0000);
  endproperty
  a_idle_glass: assert property (p_idle_glass) else $error("glass driven while inactive");

  property p_bias_exclusive;
    o_analog.bias_half |-> !o_analog.bias_static;
  endproperty
  a_bias_exclusive: assert property (p_bias_exclusive) else $error("half and static bias together");

  property p_ref_feeds_contrast;
    o_analog.ref_enable |-> (o_analog.contrast_on && o_analog.ladder_on);
  endproperty
  a_ref_feeds_contrast: assert property (p_ref_feeds_contrast) else $error("reference without contrast");

  property p_buffer_needs_ref;
    o_analog.ref_buffer_on |-> o_analog.ref_enable;
  endproperty
  a_buffer_needs_ref: assert property (p_buffer_needs_ref) else $error("buffer on without reference");

  // Pin enables follow a reference write two cycles on
  property p_bias_pins;
    (i_wr_en && i_clk_en && i_addr == `LCD_OFF_REF) ##1 !(i_wr_en && i_addr == `LCD_OFF_REF)
      |=> o_analog.bias_pin_en == $past(i_wr_data[3:1], 2);
  endproperty
  a_bias_pins: assert property (p_bias_pins) else $error("bias pin enables wrong");
endmodule : lcd_segment_driver_control_monitor

bind lcd_segment_driver_control lcd_segment_driver_control_monitor u_lcd_segment_driver_control_monitor (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
  .i_wr_en(i_wr_en), .o_seg_data(o_seg_data), .o_com_sel(o_com_sel), .o_active(o_active), .o_analog(o_analog)
);

// ---- sim/lcd_segment_driver_control_bench.sv ----
// Self-checking bench for the segment display driver control block.
// Assumes one-cycle read latency and slow oscillators made here.
`timescale 1ns/1ps
`include "lcd_seg_map.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end

module lcd_segment_driver_control_bench;
  logic i_clk_sys = 1'b0, i_srst = 1'b1, i_wr_en = 1'b0, i_rd_en = 1'b0, i_sleep = 1'b0, i_clk_en = 1'b1;
  logic i_xtal_32k = 1'b0, i_lfosc_31k = 1'b0, i_ladder_mode_b = 1'b0;
  logic [4:0] i_addr = 5'h00;
  logic [7:0] i_wr_data = 8'h00, o_rd_data;
  logic [23:0] o_seg_data, o_seg_pin_en;
  logic [3:0] o_com_sel;
  logic o_phase, o_active;
  lcd_seg_pkg::analog_ctrl_s o_analog;
  logic [95:0] image, img_exp;
  int miscompares = 0, checks_done = 0, osc_cnt = 0;

  lcd_segment_driver_control u_lcd_segment_driver_control (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data), .i_sleep(i_sleep), .i_xtal_32k(i_xtal_32k), .i_lfosc_31k(i_lfosc_31k),
    .i_ladder_mode_b(i_ladder_mode_b), .o_seg_data(o_seg_data), .o_seg_pin_en(o_seg_pin_en),
    .o_com_sel(o_com_sel), .o_phase(o_phase), .o_active(o_active), .o_analog(o_analog));
  lcd_glass_panel u_lcd_glass_panel (.i_clk(i_clk_sys), .i_com_sel(o_com_sel), .i_seg_data(o_seg_data),
    .o_image(image));

  // ****************************************
  // Clock, oscillators and bus tasks
  // ****************************************
  always #20 i_clk_sys = ~i_clk_sys;

  // Oscillators scaled down so a run stays short: 40 and 50 cycle periods
  always @(posedge i_clk_sys) begin
    osc_cnt <= osc_cnt + 1;
    i_xtal_32k <= (osc_cnt % 40) < 20;
    i_lfosc_31k <= (osc_cnt % 50) < 25;
  end

  function automatic logic [7:0] pix(input int i);
    return {i[3:0], ~i[3:0]};
  endfunction : pix

  // Strobe held high for n cycles gives n back-to-back writes
  task automatic wrn(input logic [4:0] a, input logic [7:0] d, input int n);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    repeat (n) @(posedge i_clk_sys);
    i_wr_en <= 1'b0;
  endtask : wrn

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    wrn(a, d, 1);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_clk_sys);
    i_rd_en <= 1'b0;
    #1;
    `CHK(o_rd_data, e)
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : tick

  // Aligns on one common change, then counts cycles to the next
  task automatic gap(input int e);
    int n;
    logic [3:0] c;
    for (int k = 0; k < 2; k++) begin
      c = o_com_sel;
      n = 0;
      while (o_com_sel === c && n < 5000) begin
        tick(1);
        n++;
      end
    end
    `CHK(n, e)
  endtask : gap

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #3ms;
    miscompares++;
    print_verdict();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    rd(`LCD_OFF_MAIN, 8'h03);
    rd(`LCD_OFF_PHASE, 8'h13);
    rd(`LCD_OFF_CST, 8'h00);
    rd(5'h07, 8'h00);
    for (int i = 0; i < 12; i++) begin
      wr(`LCD_OFF_DATA0 + i[4:0], pix(i));
      img_exp[8*i +: 8] = pix(i);
    end
    // Pixel memory must survive a later reset
    @(posedge i_clk_sys);
    i_srst <= 1'b1;
    @(posedge i_clk_sys);
    i_srst <= 1'b0;
    for (int i = 0; i < 12; i++) rd(`LCD_OFF_DATA0 + i[4:0], pix(i));
    rd(`LCD_OFF_REF, 8'h00);
    wr(`LCD_OFF_REF, 8'hFF);
    rd(`LCD_OFF_REF, 8'hEE);
    wr(`LCD_OFF_CST, 8'hFF);
    rd(`LCD_OFF_CST, 8'h07);
    // A frozen block must ignore a write
    @(posedge i_clk_sys);
    i_clk_en <= 1'b0;
    wr(`LCD_OFF_CST, 8'h02);
    i_clk_en <= 1'b1;
    rd(`LCD_OFF_CST, 8'h07);
    for (int i = 0; i < 3; i++) begin
      rd(`LCD_OFF_SEGEN0 + i[4:0], 8'h00);
      wr(`LCD_OFF_SEGEN0 + i[4:0], 8'h5A ^ i[7:0]);
    end
    tick(2);
    `CHK(o_seg_pin_en, 24'h58_5B5A)
    // Sysclk source, type B, four commons
    wr(`LCD_OFF_PHASE, 8'h80);
    wr(`LCD_OFF_MAIN, 8'h83);
    tick(2);
    `CHK(o_active, 1'b1)
    `CHK(o_com_sel, 4'b0001)
    `CHK(o_seg_data, {pix(2), pix(1), pix(0)})
    `CHK(o_analog, 13'h07FF)
    @(posedge i_clk_sys);
    i_ladder_mode_b <= 1'b1;
    tick(2);
    `CHK(o_analog.ref_buffer_on, 1'b0)
    gap(256);
    wr(`LCD_OFF_PHASE, 8'h83);
    gap(1024);
    `CHK(image, img_exp)
    wr(`LCD_OFF_PHASE, 8'h00);
    gap(512);
    `CHK(o_phase, 1'b0)
    tick(256);
    `CHK(o_phase, 1'b1)
    // Writing every cycle must hit a closed window
    wrn(`LCD_OFF_DATA0, pix(0), 600);
    rd(`LCD_OFF_MAIN, 8'hA3);
    wr(`LCD_OFF_MAIN, 8'hA3);
    rd(`LCD_OFF_MAIN, 8'hA3);
    wr(`LCD_OFF_MAIN, 8'h83);
    rd(`LCD_OFF_MAIN, 8'h83);
    wr(`LCD_OFF_PHASE, 8'h40);
    wr(`LCD_OFF_MAIN, 8'h81);
    tick(2);
    `CHK(o_analog.bias_half, 1'b1)
    wr(`LCD_OFF_PHASE, 8'h00);
    wr(`LCD_OFF_MAIN, 8'h80);
    tick(2);
    `CHK({o_analog.bias_static, o_analog.bias_half}, 2'b10)
    // Oscillator sources keep the glass alive in sleep
    wr(`LCD_OFF_MAIN, 8'h87);
    i_sleep <= 1'b1;
    gap(80);
    wr(`LCD_OFF_MAIN, 8'h8B);
    gap(100);
    wr(`LCD_OFF_MAIN, 8'h8F);
    gap(100);
    wr(`LCD_OFF_MAIN, 8'hCB);
    tick(2);
    `CHK(o_active, 1'b0)
    wr(`LCD_OFF_MAIN, 8'h83);
    tick(2);
    `CHK(o_active, 1'b0)
    @(posedge i_clk_sys);
    i_sleep <= 1'b0;
    tick(3);
    `CHK(o_active, 1'b1)
    wr(`LCD_OFF_MAIN, 8'h03);
    tick(2);
    `CHK(o_active, 1'b0)
    print_verdict();
  end
endmodule : lcd_segment_driver_control_bench
